// >>> rtl/jmp_pkg.sv
// package: constants and types of the mechanical jam protection stage
package jmp_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_STATUS    = 8'h04;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h0c;
	localparam logic [7:0] OFF_CNT_START = 8'h10;
	localparam logic [7:0] OFF_CNT_TRIP  = 8'h14;
	localparam logic [7:0] OFF_CNT_BLOCK = 8'h18;
	localparam logic [7:0] OFF_PREFAULT  = 8'h1c;
	localparam logic [7:0] OFF_TSTAMP    = 8'h20;
	// group g: threshold at OFF_GRP_BASE + 8*g, config at + 4
	localparam logic [7:0] OFF_GRP_BASE  = 8'h40;
	localparam int         NUM_GROUPS    = 8;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CTRL_CHAN_LSB  = 0;
	localparam int CTRL_FORCE_LSB = 2;
	localparam int CFG_MODE_BIT   = 31;
	localparam int EVB_START      = 0;
	localparam int EVB_TRIP       = 1;
	localparam int EVB_BLOCK      = 2;
	localparam int STAT_PICKUP    = 3;
	localparam int STAT_GROUP_LSB = 4;
	localparam int STAT_RUN_BIT   = 7;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [3:0]  CTRL_RST     = 4'h0;
	localparam logic [2:0]  IRQ_MASK_RST = 3'h0;
	localparam logic [15:0] THRESH_RST   = 16'h0200;
	localparam logic [20:0] DELAY_RST    = 21'h000000;
	localparam logic        MODE_RST     = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// forced status codes and channel choices
	localparam logic [1:0] FORCE_NORMAL  = 2'h0;
	localparam logic [1:0] FORCE_START   = 2'h1;
	localparam logic [1:0] FORCE_TRIP    = 2'h2;
	localparam logic [1:0] FORCE_BLOCKED = 2'h3;
	localparam logic [1:0] CHAN_ALL      = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS   = 8;
	localparam int STAMP_RES_NS    = 1000000;
	localparam int MS_CYCLES       = STAMP_RES_NS / CLK_PERIOD_NS;
	localparam int SAMPLE_MS       = 5;
	localparam int PF_LAG_MS       = 20;
	localparam int PF_WIN_MS       = 20;
	localparam int PF_LAG          = PF_LAG_MS / SAMPLE_MS;
	localparam int PF_WIN          = PF_WIN_MS / SAMPLE_MS;
	localparam int PF_DEPTH        = PF_LAG + PF_WIN;
	localparam logic [22:0] RELEASE_PCT = 23'h000061;
	localparam logic [22:0] FULL_PCT    = 23'h000064;

	////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_TRIP,
		ST_BLOCK
	} jmp_state_t;

	typedef struct packed {
		logic        delayed;
		logic [20:0] delay_ms;
		logic [15:0] thresh;
	} jmp_grp_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] phase_a_rms_current;
		logic [15:0] phase_b_rms_current;
		logic [15:0] phase_c_rms_current;
	} jmp_meas_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  chg;
		logic [2:0]  lvl;
		logic [31:0] stamp_ms;
	} jmp_event_t;

	typedef struct packed {
		jmp_state_t            fsm;
		logic [20:0]           timer;
		logic [31:0]           ms_div;
		logic [31:0]           tstamp;
		logic                  pickup;
		logic [2:0]            outs;
		jmp_event_t            evt;
		logic [3:0]            ctrl;
		logic [2:0]            irq_stat;
		logic [2:0]            irq_mask;
		logic [2:0][31:0]      cnt;
		logic [15:0]           prefault;
		jmp_grp_t [NUM_GROUPS-1:0] grp;
		logic                  wr_pend;
		logic [7:0]            wr_addr;
		logic [31:0]           rdata;
	} jmp_top_state_t;

	typedef struct packed {
		logic [PF_DEPTH-1:0][15:0] hist;
		logic [15:0]               avg;
	} jmp_pf_state_t;

endpackage

// >>> rtl/jmp_prefault.sv
// module: pre-fault history averager over the 5 ms sample stream
module jmp_prefault (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// samples
	input  wire logic        sample_valid,
	input  wire logic [15:0] sample,
	// result
	output logic      [15:0] avg
);

	jmp_pkg::jmp_pf_state_t q;
	jmp_pkg::jmp_pf_state_t d;
	logic [17:0]            sum;

	////////////////////////////////////////////////////////////////////////
	// lagged window average
	always_comb begin
		d   = q;
		sum = 18'h00000;
		// oldest entries only: the window ending 20 ms back
		for (int i = jmp_pkg::PF_LAG; i < jmp_pkg::PF_DEPTH; i++) begin
			sum = sum + 18'(q.hist[i]);
		end
		if (sample_valid) begin
			d.hist = {q.hist[jmp_pkg::PF_DEPTH-2:0], sample};
			d.avg  = 16'(sum / 18'(jmp_pkg::PF_WIN));
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign avg = q.avg;

endmodule

// >>> rtl/jmp_stage.sv
// module: mechanical jam overcurrent stage with AHB-Lite registers
//
// Notes on behaviour
// - operate only while motor running and not starting
// - eight setting groups; one active, picked by shared select input
// - instant or definite-time delayed operating mode
// - start, trip and blocked outputs available directly
// - time-stamped event on every rise and fall of each output
// - instant mode issues start and trip in one event, same stamp
// - time stamps count milliseconds
// - separate cumulative counters for start, trip and blocked
// - three phase rms currents, one sample every 5 ms
// - capture 20 ms average ending 20 ms before start or trip
// - a setting chooses which input channel is measured
// - general settings stay put across group change or edit
// - forcing code 1..3 overrides status, only when forcing enabled
// - pick-up when any selected phase exceeds common threshold
// - release only below 97 percent of threshold
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
module jmp_stage #(
	parameter int unsigned MS_TICK_CYCLES = jmp_pkg::MS_CYCLES
) (
	// clock and reset
	input  wire logic              CLK_SYS,
	input  wire logic              RST_B,
	// AHB-Lite slave
	input  wire logic              HSEL,
	input  wire logic [31:0]       HADDR,
	input  wire logic [1:0]        HTRANS,
	input  wire logic              HWRITE,
	input  wire logic [2:0]        HSIZE,
	input  wire logic [31:0]       HWDATA,
	input  wire logic              HREADY,
	output logic      [31:0]       HRDATA,
	output logic                   HREADYOUT,
	output logic                   HRESP,
	// measurement and motor status
	input  wire jmp_pkg::jmp_meas_t MEAS,
	input  wire logic              MOTOR_RUNNING,
	input  wire logic              MOTOR_STARTING,
	// blocking, group select, forcing
	input  wire logic              BLOCK_IN,
	input  wire logic [2:0]        GROUP_SEL,
	input  wire logic              FORCE_ENABLE,
	// stage outputs
	output logic                   START_OUT,
	output logic                   TRIP_OUT,
	output logic                   BLOCKED_OUT,
	// event stream and interrupt
	output jmp_pkg::jmp_event_t    EVT,
	output logic                   IRQ
);

	jmp_pkg::jmp_top_state_t q;
	jmp_pkg::jmp_top_state_t d;

	logic [2:0][15:0] cur;
	logic [2:0]       over_set;
	logic [2:0]       above_rel;
	logic [2:0]       chan_mask;
	logic [15:0]      sel_mag;
	logic [15:0]      pf_avg;
	jmp_pkg::jmp_grp_t act;
	logic             run_ok;
	logic             tick;
	logic             addr_ok;
	logic [2:0]       raw_out;
	logic [2:0]       rise;
	logic [2:0]       w1c;
	logic [2:0]       gidx;

	////////////////////////////////////////////////////////////////////////
	// per-phase comparators

	assign cur[0] = MEAS.phase_a_rms_current;
	assign cur[1] = MEAS.phase_b_rms_current;
	assign cur[2] = MEAS.phase_c_rms_current;

	assign act = q.grp[GROUP_SEL];

	always_comb begin
		case (q.ctrl[jmp_pkg::CTRL_CHAN_LSB +: 2])
			2'h1:    chan_mask = 3'h1;
			2'h2:    chan_mask = 3'h2;
			2'h3:    chan_mask = 3'h4;
			default: chan_mask = 3'h7;
		endcase
	end

	for (genvar i = 0; i < 3; i++) begin : g_phase
		assign over_set[i]  = cur[i] > act.thresh;
		// 97 percent release, cross-multiplied to avoid a divider
		assign above_rel[i] = (23'(cur[i]) * jmp_pkg::FULL_PCT) >=
		                      (23'(act.thresh) * jmp_pkg::RELEASE_PCT);
	end

	// largest selected phase feeds the pre-fault history
	always_comb begin
		sel_mag = 16'h0000;
		for (int i = 0; i < 3; i++) begin
			if (chan_mask[i] && cur[i] > sel_mag) begin
				sel_mag = cur[i];
			end
		end
	end

	jmp_prefault u_prefault (
		.clk          (CLK_SYS),
		.rst_b        (RST_B),
		.sample_valid (MEAS.valid),
		.sample       (sel_mag),
		.avg          (pf_avg)
	);

	assign run_ok  = MOTOR_RUNNING && !MOTOR_STARTING;
	assign tick    = q.ms_div == 32'(MS_TICK_CYCLES - 1);
	assign addr_ok = HSEL && HREADY && HTRANS[1];
	assign gidx    = q.wr_addr[5:3];

	////////////////////////////////////////////////////////////////////////
	// register read mux, evaluated in the address phase
	function automatic logic [31:0] rd_mux(
		input jmp_pkg::jmp_top_state_t s,
		input logic [7:0]              a,
		input logic [2:0]              grp_sel
	);
		logic [31:0] r;
		r = 32'h00000000;
		if (a >= jmp_pkg::OFF_GRP_BASE && a[1:0] == 2'h0) begin
			if (a[2]) begin
				r[jmp_pkg::CFG_MODE_BIT] = s.grp[a[5:3]].delayed;
				r[20:0]                  = s.grp[a[5:3]].delay_ms;
			end else begin
				r[15:0] = s.grp[a[5:3]].thresh;
			end
		end else begin
			case (a)
				jmp_pkg::OFF_CTRL:      r[3:0]  = s.ctrl;
				jmp_pkg::OFF_STATUS: begin
					r[2:0]                     = s.outs;
					r[jmp_pkg::STAT_PICKUP]    = s.pickup;
					r[jmp_pkg::STAT_GROUP_LSB +: 3] = grp_sel;
					r[jmp_pkg::STAT_RUN_BIT]   = s.fsm != jmp_pkg::ST_IDLE;
				end
				jmp_pkg::OFF_IRQ_STAT:  r[2:0]  = s.irq_stat;
				jmp_pkg::OFF_IRQ_MASK:  r[2:0]  = s.irq_mask;
				jmp_pkg::OFF_CNT_START: r       = s.cnt[jmp_pkg::EVB_START];
				jmp_pkg::OFF_CNT_TRIP:  r       = s.cnt[jmp_pkg::EVB_TRIP];
				jmp_pkg::OFF_CNT_BLOCK: r       = s.cnt[jmp_pkg::EVB_BLOCK];
				jmp_pkg::OFF_PREFAULT:  r[15:0] = s.prefault;
				jmp_pkg::OFF_TSTAMP:    r       = s.tstamp;
				default:                r       = 32'h00000000;
			endcase
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		d       = q;
		raw_out = 3'h0;
		rise    = 3'h0;
		w1c     = 3'h0;

		d.ms_div = tick ? 32'h00000000 : q.ms_div + 32'h00000001;
		if (tick) begin
			d.tstamp = q.tstamp + 32'h00000001;
		end

		// pick-up with hysteresis, on each fresh sample
		if (MEAS.valid) begin
			if (q.pickup) begin
				d.pickup = run_ok && |(above_rel & chan_mask);
			end else begin
				d.pickup = run_ok && |(over_set & chan_mask);
			end
		end

		// blocking is looked at once per sample, like the program cycle
		case (q.fsm)
			jmp_pkg::ST_IDLE: begin
				if (MEAS.valid && d.pickup) begin
					d.timer = 21'h000000;
					if (BLOCK_IN) begin
						d.fsm = jmp_pkg::ST_BLOCK;
					end else if (!act.delayed) begin
						d.fsm = jmp_pkg::ST_TRIP;
					end else begin
						d.fsm = jmp_pkg::ST_START;
					end
				end
			end
			jmp_pkg::ST_START: begin
				if (MEAS.valid && !d.pickup) begin
					d.fsm = jmp_pkg::ST_IDLE;
				end else if (MEAS.valid && BLOCK_IN) begin
					d.fsm = jmp_pkg::ST_BLOCK;
				end else if (q.timer >= act.delay_ms) begin
					d.fsm = jmp_pkg::ST_TRIP;
				end else if (tick) begin
					d.timer = q.timer + 21'h000001;
				end
			end
			jmp_pkg::ST_TRIP: begin
				if (MEAS.valid && !d.pickup) begin
					d.fsm = jmp_pkg::ST_IDLE;
				end else if (MEAS.valid && BLOCK_IN) begin
					d.fsm = jmp_pkg::ST_BLOCK;
				end
			end
			jmp_pkg::ST_BLOCK: begin
				if (MEAS.valid && (!d.pickup || !BLOCK_IN)) begin
					d.fsm = jmp_pkg::ST_IDLE;
				end
			end
			default: d.fsm = jmp_pkg::ST_IDLE;
		endcase

		raw_out[jmp_pkg::EVB_START] = d.fsm == jmp_pkg::ST_START ||
		                              d.fsm == jmp_pkg::ST_TRIP;
		raw_out[jmp_pkg::EVB_TRIP]  = d.fsm == jmp_pkg::ST_TRIP;
		raw_out[jmp_pkg::EVB_BLOCK] = d.fsm == jmp_pkg::ST_BLOCK;

		// forced status overrides only under global enable
		if (FORCE_ENABLE) begin
			case (q.ctrl[jmp_pkg::CTRL_FORCE_LSB +: 2])
				jmp_pkg::FORCE_START:   d.outs = 3'h1;
				jmp_pkg::FORCE_TRIP:    d.outs = 3'h3;
				jmp_pkg::FORCE_BLOCKED: d.outs = 3'h4;
				default:                d.outs = raw_out;
			endcase
		end else begin
			d.outs = raw_out;
		end
		rise = d.outs & ~q.outs;

		// one event word per change, all changed bits share a stamp
		d.evt.valid    = |(d.outs ^ q.outs);
		d.evt.chg      = d.outs ^ q.outs;
		d.evt.lvl      = d.outs;
		d.evt.stamp_ms = q.tstamp;

		for (int i = 0; i < 3; i++) begin
			if (rise[i]) begin
				d.cnt[i] = q.cnt[i] + 32'h00000001;
			end
		end

		// pre-fault value latched at start or trip
		if (rise[jmp_pkg::EVB_START] || rise[jmp_pkg::EVB_TRIP]) begin
			d.prefault = pf_avg;
		end

		// bus: address phase
		d.wr_pend = addr_ok && HWRITE;
		if (addr_ok) begin
			d.wr_addr = HADDR[7:0];
			if (!HWRITE) begin
				d.rdata = rd_mux(q, HADDR[7:0], GROUP_SEL);
			end
		end

		// bus: data phase writes
		if (q.wr_pend) begin
			if (q.wr_addr >= jmp_pkg::OFF_GRP_BASE &&
			    q.wr_addr[1:0] == 2'h0) begin
				// group edits never touch general control
				if (q.wr_addr[2]) begin
					d.grp[gidx].delayed  = HWDATA[jmp_pkg::CFG_MODE_BIT];
					d.grp[gidx].delay_ms = HWDATA[20:0];
				end else begin
					d.grp[gidx].thresh = HWDATA[15:0];
				end
			end else begin
				case (q.wr_addr)
					jmp_pkg::OFF_CTRL:     d.ctrl     = HWDATA[3:0];
					jmp_pkg::OFF_IRQ_STAT: w1c        = HWDATA[2:0];
					jmp_pkg::OFF_IRQ_MASK: d.irq_mask = HWDATA[2:0];
					default:               d.ctrl     = q.ctrl;
				endcase
			end
		end

		// a new event wins over a clear in the same cycle
		d.irq_stat = (q.irq_stat & ~w1c) | rise;
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			q          <= '0;
			q.fsm      <= jmp_pkg::ST_IDLE;
			q.ctrl     <= jmp_pkg::CTRL_RST;
			q.irq_mask <= jmp_pkg::IRQ_MASK_RST;
			for (int g = 0; g < jmp_pkg::NUM_GROUPS; g++) begin
				q.grp[g].thresh   <= jmp_pkg::THRESH_RST;
				q.grp[g].delay_ms <= jmp_pkg::DELAY_RST;
				q.grp[g].delayed  <= jmp_pkg::MODE_RST;
			end
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign HRDATA      = q.rdata;
	// zero wait states keep the slave simple; every access is OKAY
	assign HREADYOUT   = 1'b1;
	assign HRESP       = 1'b0;
	assign START_OUT   = q.outs[jmp_pkg::EVB_START];
	assign TRIP_OUT    = q.outs[jmp_pkg::EVB_TRIP];
	assign BLOCKED_OUT = q.outs[jmp_pkg::EVB_BLOCK];
	assign EVT         = q.evt;
	assign IRQ         = |(q.irq_stat & q.irq_mask);

endmodule

// >>> test/jmp_meas_model.sv
// model: phase current sampler and motor status source
module jmp_meas_model #(
	parameter int SAMPLE_CYC = 50
) (
	// clock and reset
	input wire logic           clk,
	input wire logic           rst_b,
	// commanded levels
	input wire logic [15:0]    cur_a,
	input wire logic [15:0]    cur_b,
	input wire logic [15:0]    cur_c,
	input wire logic           run_cmd,
	input wire logic           start_cmd,
	// to the stage
	output jmp_pkg::jmp_meas_t meas,
	output logic               running,
	output logic               starting
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;

	always_ff @(posedge clk) begin
		cnt <= (!rst_b || cnt == SAMPLE_CYC - 1) ? 0 : cnt + 1;
	end

	always_comb begin
		meas.valid = rst_b && cnt == SAMPLE_CYC - 1;
		// outside the sample cycle the values mean nothing: show junk
		meas.phase_a_rms_current = meas.valid ? cur_a : ~cur_a;
		meas.phase_b_rms_current = meas.valid ? cur_b : ~cur_b;
		meas.phase_c_rms_current = meas.valid ? cur_c : ~cur_c;
	end

	assign running  = run_cmd;
	assign starting = start_cmd;
endmodule

// >>> test/jmp_stage_assertions.sv
// checker: port-level properties of the jam overcurrent stage
module jmp_stage_assertions (
	// clock and reset
	input wire logic                CLK_SYS,
	input wire logic                RST_B,
	// inputs watched
	input wire jmp_pkg::jmp_meas_t  MEAS,
	input wire logic                MOTOR_RUNNING,
	input wire logic                MOTOR_STARTING,
	input wire logic                BLOCK_IN,
	input wire logic                FORCE_ENABLE,
	// outputs watched
	input wire logic                START_OUT,
	input wire logic                TRIP_OUT,
	input wire logic                BLOCKED_OUT,
	input wire jmp_pkg::jmp_event_t EVT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);

	wire  [2:0] outs = {BLOCKED_OUT, TRIP_OUT, START_OUT};
	logic [1:0] fe_q;
	// forcing moves outputs at any edge, so cause checks wait it out
	wire        free = !FORCE_ENABLE && fe_q == 2'h0;

	always_ff @(posedge CLK_SYS) begin
		fe_q <= RST_B ? {fe_q[0], FORCE_ENABLE} : 2'h0;
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_gated;
		MEAS.valid && !FORCE_ENABLE && (!MOTOR_RUNNING || MOTOR_STARTING);
	endsequence
	sequence s_quiet;
		MEAS.valid && !FORCE_ENABLE && MEAS.phase_a_rms_current == 16'h0
			&& MEAS.phase_b_rms_current == 16'h0
			&& MEAS.phase_c_rms_current == 16'h0;
	endsequence

	////////////////////////////////////////////////////////////////////////
	a_run_gate: assert property (s_gated |=> outs == 3'h0)
		else $error("stage active while motor not running");
	a_quiet_clear: assert property (s_quiet |=> outs == 3'h0)
		else $error("outputs held after a zero sample");
	a_evt_moved: assert property (
		outs != $past(outs) |-> EVT.valid && EVT.chg == (outs ^ $past(outs)))
		else $error("output change without matching event");
	a_evt_level: assert property (
		EVT.valid |-> EVT.chg != 3'h0 && EVT.lvl == outs)
		else $error("event levels disagree with outputs");
	a_trip_start: assert property (TRIP_OUT |-> START_OUT)
		else $error("trip without start");
	a_block_excl: assert property (BLOCKED_OUT |-> !START_OUT)
		else $error("blocked and start together");
	a_start_cause: assert property (
		$rose(START_OUT) && free
		|-> $past(MEAS.valid && MOTOR_RUNNING && !MOTOR_STARTING))
		else $error("start rose without a running sample");
	a_block_cause: assert property (
		$rose(BLOCKED_OUT) && free |-> $past(MEAS.valid && BLOCK_IN))
		else $error("blocked rose without a blocked sample");
endmodule

bind jmp_stage jmp_stage_assertions i_jmp_stage_assertions (
	.CLK_SYS(CLK_SYS), .RST_B(RST_B), .MEAS(MEAS),
	.MOTOR_RUNNING(MOTOR_RUNNING), .MOTOR_STARTING(MOTOR_STARTING),
	.BLOCK_IN(BLOCK_IN), .FORCE_ENABLE(FORCE_ENABLE),
	.START_OUT(START_OUT), .TRIP_OUT(TRIP_OUT),
	.BLOCKED_OUT(BLOCKED_OUT), .EVT(EVT)
);

// >>> test/testbench.sv
// testbench: self-checking bench of the jam overcurrent stage
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS    = 10;
	localparam int LIMIT = 10000;
	logic        clk    = 1'b0;
	logic        rst_b  = 1'b0;
	logic        hsel   = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr  = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [15:0] c [3]  = '{16'h0, 16'h0, 16'h0};
	logic [2:0]  fx [4] = '{3'b000, 3'b001, 3'b011, 3'b100};
	logic        run    = 1'b0;
	logic        stg    = 1'b0;
	logic        blk    = 1'b0;
	logic        fe     = 1'b0;
	logic [2:0]  grp    = 3'h0;
	logic [31:0] rd;
	logic [31:0] t0;
	wire  [31:0] hrdata;
	wire         hready;
	wire         hresp;
	wire         running;
	wire         starting;
	wire         irq;
	wire  [2:0]  outs;
	jmp_pkg::jmp_meas_t  meas;
	jmp_pkg::jmp_event_t evt;
	int          miscompares = 0;
	int          compares    = 0;
	int          cyc         = 0;
	int          d;
	int          ph;
	int          rel;

	always #4 clk = ~clk;

	jmp_stage #(.MS_TICK_CYCLES(MS)) i_jmp_stage (
		.CLK_SYS(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
		.HRESP(hresp), .MEAS(meas), .MOTOR_RUNNING(running),
		.MOTOR_STARTING(starting), .BLOCK_IN(blk), .GROUP_SEL(grp),
		.FORCE_ENABLE(fe), .START_OUT(outs[0]), .TRIP_OUT(outs[1]),
		.BLOCKED_OUT(outs[2]), .EVT(evt), .IRQ(irq)
	);

	jmp_meas_model #(.SAMPLE_CYC(5 * MS)) i_jmp_meas_model (
		.clk(clk), .rst_b(rst_b), .cur_a(c[0]), .cur_b(c[1]),
		.cur_c(c[2]), .run_cmd(run), .start_cmd(stg), .meas(meas),
		.running(running), .starting(starting)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// the bus never waits here, but the master still honours hready
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] wd, output logic [31:0] r);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		bus(1'b1, a, wd, rd);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, rd);
		chk(rd, e);
	endtask

	// outputs of a sample show in the cycle after it is taken
	task automatic smp();
		@(posedge clk iff meas.valid);
		@(posedge clk);
	endtask

	task automatic exo(input logic [2:0] e);
		chk({29'h0, outs}, {29'h0, e});
	endtask

	// a stamp holds the ms count of the cycle before the change; it is
	// read one cycle later, and the count starts with reset release
	function automatic logic [31:0] exp_stamp();
		return 32'((cyc - rel - 2) / MS);
	endfunction

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			miscompares++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		ph = $urandom(32'h11dcacb5);
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		rel = cyc;
		rc(jmp_pkg::OFF_CTRL, 32'h0);
		rc(jmp_pkg::OFF_GRP_BASE, 32'h200);
		rc(jmp_pkg::OFF_IRQ_MASK, 32'h0);
		rc(8'h3c, 32'h0);
		bus(1'b0, jmp_pkg::OFF_TSTAMP, 32'h0, t0);
		repeat (10 * MS - 3) @(posedge clk);
		rc(jmp_pkg::OFF_TSTAMP, t0 + 32'h0000000a);
		wr(jmp_pkg::OFF_IRQ_MASK, 32'h1);
		run <= 1'b1;
		c <= '{16'h0100, 16'h0080, 16'h0040};
		repeat (10) smp();
		c[0] <= 16'h0300;
		smp();
		exo(3'b011);
		chk({25'h0, evt.valid, evt.chg, evt.lvl}, 32'h5b);
		chk(evt.stamp_ms, exp_stamp());
		chk({31'h0, irq}, 32'h1);
		rc(jmp_pkg::OFF_CNT_START, 32'h1);
		rc(jmp_pkg::OFF_CNT_TRIP, 32'h1);
		rc(jmp_pkg::OFF_CNT_BLOCK, 32'h0);
		rc(jmp_pkg::OFF_PREFAULT, 32'h0100);
		rc(jmp_pkg::OFF_STATUS, 32'h8b);
		rc(jmp_pkg::OFF_IRQ_STAT, 32'h3);
		wr(jmp_pkg::OFF_IRQ_STAT, 32'h7);
		rc(jmp_pkg::OFF_IRQ_STAT, 32'h0);
		chk({31'h0, irq}, 32'h0);
		c[0] <= 16'h01f1;
		smp();
		exo(3'b011);
		c[0] <= 16'h01f0;
		smp();
		exo(3'b000);
		chk({25'h0, evt.valid, evt.chg, evt.lvl}, 32'h58);
		wr(jmp_pkg::OFF_IRQ_MASK, 32'h0);
		for (int k = 0; k < 6; k++) begin
			ph = $urandom_range(2, 0);
			for (int j = 0; j < 3; j++) begin
				c[j] <= (j == ph) ? 16'($urandom_range(16'h0fff, 16'h0201))
					: 16'($urandom_range(16'h01ef, 0));
			end
			smp();
			exo(3'b011);
			c <= '{16'h0, 16'h0, 16'h0};
			smp();
			exo(3'b000);
		end
		rc(jmp_pkg::OFF_IRQ_STAT, 32'h3);
		chk({31'h0, irq}, 32'h0);
		wr(jmp_pkg::OFF_IRQ_MASK, 32'h2);
		@(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(jmp_pkg::OFF_IRQ_STAT, 32'h2);
		rc(jmp_pkg::OFF_IRQ_STAT, 32'h1);
		chk({31'h0, irq}, 32'h0);
		stg <= 1'b1;
		c[0] <= 16'h0300;
		smp();
		exo(3'b000);
		stg <= 1'b0;
		smp();
		exo(3'b011);
		blk <= 1'b1;
		smp();
		exo(3'b100);
		blk <= 1'b0;
		smp();
		chk({31'h0, outs[2]}, 32'h0);
		c[0] <= 16'h0;
		smp();
		rc(jmp_pkg::OFF_CNT_BLOCK, 32'h1);
		wr(jmp_pkg::OFF_CTRL, 32'h1);
		c[1] <= 16'h0300;
		smp();
		exo(3'b000);
		wr(jmp_pkg::OFF_CTRL, 32'h2);
		smp();
		exo(3'b011);
		wr(jmp_pkg::OFF_CTRL, 32'h3);
		smp();
		exo(3'b000);
		wr(jmp_pkg::OFF_CTRL, 32'h1);
		wr(jmp_pkg::OFF_GRP_BASE + 8'h18, 32'h0400);
		wr(jmp_pkg::OFF_GRP_BASE + 8'h1c, 32'h80000002);
		grp <= 3'h3;
		c[0] <= 16'h0300;
		smp();
		exo(3'b000);
		rc(jmp_pkg::OFF_CTRL, 32'h1);
		c[0] <= 16'h0500;
		smp();
		exo(3'b001);
		chk({25'h0, evt.valid, evt.chg, evt.lvl}, 32'h49);
		chk(evt.stamp_ms, exp_stamp());
		d = 0;
		while (outs[1] !== 1'b1 && d < 5 * MS) begin
			@(posedge clk);
			d++;
		end
		chk(32'(d >= 2 * MS - 1 && d <= 3 * MS + 1), 32'h1);
		chk({25'h0, evt.valid, evt.chg, evt.lvl}, 32'h53);
		chk(evt.stamp_ms, exp_stamp());
		c <= '{16'h0, 16'h0, 16'h0};
		grp <= 3'h0;
		wr(jmp_pkg::OFF_CTRL, 32'h0);
		smp();
		exo(3'b000);
		fe <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr(jmp_pkg::OFF_CTRL, 32'(k) << 2);
			repeat (2) @(posedge clk);
			exo(fx[k]);
		end
		wr(jmp_pkg::OFF_CTRL, 32'h8);
		fe <= 1'b0;
		repeat (3) @(posedge clk);
		exo(3'b000);
		tally_and_finish();
	end
endmodule
